// File: pkg/i2c_port_pkg.sv
`default_nettype none
package i2c_port_pkg;

	// Fixed upper part of the 7-bit node address
	localparam logic [3:0] NODE_ADDR_UPPER = 4'hb;

	// Resolved three-level strap states, also their weight in the address sum
	localparam logic [1:0] STRAP_LOW = 2'h0;
	localparam logic [1:0] STRAP_OPEN = 2'h1;
	localparam logic [1:0] STRAP_HIGH = 2'h2;

	// Bit positions in the two-bit pad sense code of a strap
	localparam int SENSE_HI_POS = 1;
	localparam int SENSE_LO_POS = 0;

	// Settle count at which the synchronised straps are captured, on the fourth cycle after reset release
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	// Rising clock edges counted within one nine-bit frame
	localparam logic [3:0] BITS_NONE = 4'h0;
	localparam logic [3:0] BITS_BYTE = 4'h8;
	localparam logic [3:0] BITS_FRAME = 4'h9;

	// Register address and data widths seen from the serial port
	localparam int REG_ADDR_W = 16;
	localparam int REG_DATA_W = 8;

	// Write queue depth
	localparam int WR_FIFO_DEPTH = 16;

	// Bus timing: shortest clock high time of the faster mode
	localparam int SYS_CLK_MHZ = 100;
	localparam int SCL_HIGH_MIN_NS = 600;
	localparam int SCL_HIGH_MIN_CYC = (SCL_HIGH_MIN_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int SYNC_LATENCY_CYC = 4;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_HI,
		ST_ADDR_LO,
		ST_WDATA,
		ST_RDATA,
		ST_SKIP
	} xfer_state_t;

	typedef struct packed {
		logic [REG_ADDR_W-1:0] addr;
		logic [REG_DATA_W-1:0] data;
	} reg_write_t;

endpackage
`default_nettype wire

// File: rtl/serial_port_select_i2c_target.sv
`timescale 1ns/1ps
`default_nettype none
module serial_port_select_i2c_target #(
	parameter int FIFO_DEPTH = i2c_port_pkg::WR_FIFO_DEPTH
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [1:0] port_strap_upper_i,
	input wire logic [1:0] port_strap_lower_i,
	output logic spi_en_o,
	output logic i2c_en_o,
	output logic [6:0] node_addr_o,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	output logic [i2c_port_pkg::REG_ADDR_W-1:0] rd_addr_o,
	input wire logic [i2c_port_pkg::REG_DATA_W-1:0] rd_data_i,
	output logic wr_valid_o,
	input wire logic wr_ready_i,
	output logic [i2c_port_pkg::REG_ADDR_W-1:0] wr_addr_o,
	output logic [i2c_port_pkg::REG_DATA_W-1:0] wr_data_o
);

	// The sync chain plus edge detect must fit well inside one clock high time
	if (i2c_port_pkg::SCL_HIGH_MIN_CYC < i2c_port_pkg::SYNC_LATENCY_CYC) begin : g_rate_check
		$error("system clock too slow for fast-mode bus");
	end

	// Pad sense code to three-level state; both comparators firing reads as open
	function automatic logic [1:0] strap_resolve(input logic [1:0] sense);
		logic [1:0] res;
		res = i2c_port_pkg::STRAP_OPEN;
		if (sense[i2c_port_pkg::SENSE_HI_POS] && !sense[i2c_port_pkg::SENSE_LO_POS]) begin
			res = i2c_port_pkg::STRAP_HIGH;
		end else if (!sense[i2c_port_pkg::SENSE_HI_POS] && sense[i2c_port_pkg::SENSE_LO_POS]) begin
			res = i2c_port_pkg::STRAP_LOW;
		end
		return res;
	endfunction

	// Only the both-high pair hands the pins to the four-wire port
	function automatic logic spi_select(input logic [1:0] up, input logic [1:0] lo);
		return up == i2c_port_pkg::STRAP_HIGH && lo == i2c_port_pkg::STRAP_HIGH;
	endfunction

	// Strap synchronisers and one-shot capture after reset release.
	// Taking the straps once keeps a later strap disturbance from moving the address.
	logic strap_take;
	logic [1:0] up_meta_r;
	logic [1:0] up_sync_r;
	logic [1:0] lo_meta_r;
	logic [1:0] lo_sync_r;
	logic [1:0] settle_r;
	logic strap_done_r;
	logic [1:0] up_state;
	logic [1:0] lo_state;
	logic [3:0] addr_sum;

	// Straps come from pads, so two flops before any decode
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			up_meta_r <= 2'h0;
			up_sync_r <= 2'h0;
			lo_meta_r <= 2'h0;
			lo_sync_r <= 2'h0;
		end else begin
			up_meta_r <= port_strap_upper_i;
			up_sync_r <= up_meta_r;
			lo_meta_r <= port_strap_lower_i;
			lo_sync_r <= lo_meta_r;
		end
	end

	assign up_state = strap_resolve(up_sync_r);
	assign lo_state = strap_resolve(lo_sync_r);
	assign addr_sum = 4'(up_state * 3) + 4'(lo_state);

	// Capture strobe, high for one cycle once the chain has filled
	assign strap_take = !strap_done_r && settle_r == i2c_port_pkg::STRAP_SETTLE;

	// Settle counter: the straps are taken once, after the chain has filled
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			settle_r <= 2'h0;
			strap_done_r <= 1'b0;
		end else if (!strap_done_r) begin
			settle_r <= settle_r + 2'h1;
			if (settle_r == i2c_port_pkg::STRAP_SETTLE) begin
				strap_done_r <= 1'b1;
			end
		end
	end

	// Port select and node address, frozen after capture
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			spi_en_o <= 1'b0;
			i2c_en_o <= 1'b0;
			node_addr_o <= 7'h00;
		end else if (strap_take) begin
			spi_en_o <= spi_select(up_state, lo_state);
			i2c_en_o <= !spi_select(up_state, lo_state);
			node_addr_o <= {i2c_port_pkg::NODE_ADDR_UPPER, addr_sum[2:0]};
		end
	end

	// Bus line synchronisers and condition detection.
	// Both lines pass the same chain, so their relative order is kept.
	logic scl_meta_r;
	logic scl_sync_r;
	logic scl_prev_r;
	logic sda_meta_r;
	logic sda_sync_r;
	logic sda_prev_r;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	// Two flops on each line; the third only serves edge detection
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scl_meta_r <= 1'b1;
			scl_sync_r <= 1'b1;
			scl_prev_r <= 1'b1;
			sda_meta_r <= 1'b1;
			sda_sync_r <= 1'b1;
			sda_prev_r <= 1'b1;
		end else begin
			scl_meta_r <= scl_i;
			scl_sync_r <= scl_meta_r;
			scl_prev_r <= scl_sync_r;
			sda_meta_r <= sda_i;
			sda_sync_r <= sda_meta_r;
			sda_prev_r <= sda_sync_r;
		end
	end

	// Edge and condition strobes, one cycle each
	assign scl_rise = scl_sync_r & ~scl_prev_r;
	assign scl_fall = ~scl_sync_r & scl_prev_r;
	assign start_det = i2c_en_o & scl_sync_r & scl_prev_r & sda_prev_r & ~sda_sync_r;
	assign stop_det = i2c_en_o & scl_sync_r & scl_prev_r & ~sda_prev_r & sda_sync_r;

	// Transfer sequencing.
	// Everything below moves on synchronised clock and data edges only, never on the pins.
	i2c_port_pkg::xfer_state_t state_r;
	logic load_rd;
	logic [3:0] bits_r;
	logic [7:0] rx_r;
	logic [7:0] tx_r;
	logic [15:0] ptr_r;
	logic byte_end;
	logic frame_end;
	logic addr_match;
	logic ack_now;
	logic fifo_in_ready;
	logic push;
	logic tx_step;
	i2c_port_pkg::reg_write_t push_word;
	i2c_port_pkg::reg_write_t pop_word;

	// Falling edge after the eighth bit, and after the ninth (acknowledge) bit
	assign byte_end = scl_fall && bits_r == i2c_port_pkg::BITS_BYTE;
	assign frame_end = scl_fall && bits_r == i2c_port_pkg::BITS_FRAME;
	assign addr_match = rx_r[7:1] == node_addr_o;
	assign tx_step = scl_fall && state_r == i2c_port_pkg::ST_RDATA
		&& bits_r != i2c_port_pkg::BITS_NONE && bits_r < i2c_port_pkg::BITS_BYTE;

	// End of a read frame: fetch the next byte and move the pointer past it
	assign load_rd = frame_end && state_r == i2c_port_pkg::ST_RDATA;

	// Whether the byte just received is accepted; a full queue refuses data
	// An address byte meant for another node is never answered
	always_comb begin
		ack_now = 1'b0;
		case (state_r)
			i2c_port_pkg::ST_ADDR: ack_now = addr_match;
			i2c_port_pkg::ST_ADDR_HI: ack_now = 1'b1;
			i2c_port_pkg::ST_ADDR_LO: ack_now = 1'b1;
			i2c_port_pkg::ST_WDATA: ack_now = fifo_in_ready;
			default: ack_now = 1'b0;
		endcase
	end

	assign push = byte_end && state_r == i2c_port_pkg::ST_WDATA && fifo_in_ready;
	assign push_word.addr = ptr_r;
	assign push_word.data = rx_r;

	// Bit counter counts rising clock edges; start or stop drops a partial byte
	// Rises are counted, so the ninth rise is always the acknowledge slot
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bits_r <= i2c_port_pkg::BITS_NONE;
		end else if (start_det || stop_det || !i2c_en_o) begin
			bits_r <= i2c_port_pkg::BITS_NONE;
		end else if (scl_rise && bits_r != i2c_port_pkg::BITS_FRAME) begin
			bits_r <= bits_r + 4'h1;
		end else if (frame_end) begin
			bits_r <= i2c_port_pkg::BITS_NONE;
		end
	end

	// Receive shifter, sampled while clock is high, MSB first
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_r <= 8'h00;
		end else if (scl_rise && bits_r < i2c_port_pkg::BITS_BYTE) begin
			rx_r <= {rx_r[6:0], sda_sync_r};
		end
	end

	// Transfer state
	// Stop outranks start; either one abandons a half-finished byte
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= i2c_port_pkg::ST_IDLE;
		end else if (!i2c_en_o || stop_det) begin
			state_r <= i2c_port_pkg::ST_IDLE;
		end else if (start_det) begin
			state_r <= i2c_port_pkg::ST_ADDR;
		end else if (scl_rise && state_r == i2c_port_pkg::ST_RDATA
			&& bits_r == i2c_port_pkg::BITS_BYTE && sda_sync_r) begin
			state_r <= i2c_port_pkg::ST_SKIP;
		end else if (byte_end) begin
			case (state_r)
				i2c_port_pkg::ST_ADDR: begin
					if (!addr_match) begin
						state_r <= i2c_port_pkg::ST_SKIP;
					end else if (rx_r[0]) begin
						state_r <= i2c_port_pkg::ST_RDATA;
					end else begin
						state_r <= i2c_port_pkg::ST_ADDR_HI;
					end
				end
				i2c_port_pkg::ST_ADDR_HI: state_r <= i2c_port_pkg::ST_ADDR_LO;
				i2c_port_pkg::ST_ADDR_LO: state_r <= i2c_port_pkg::ST_WDATA;
				default: state_r <= state_r;
			endcase
		end
	end

	// Register pointer: loaded high byte first, advanced after each data byte
	// A refused write byte leaves the pointer alone, so a retry hits the same register
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ptr_r <= 16'h0000;
		end else if (byte_end && state_r == i2c_port_pkg::ST_ADDR_HI) begin
			ptr_r <= {rx_r, ptr_r[7:0]};
		end else if (byte_end && state_r == i2c_port_pkg::ST_ADDR_LO) begin
			ptr_r <= {ptr_r[15:8], rx_r};
		end else if (push) begin
			ptr_r <= ptr_r + 16'h0001;
		end else if (load_rd) begin
			ptr_r <= ptr_r + 16'h0001;
		end
	end

	// Read address follows the pointer; the register file answers in the same cycle
	assign rd_addr_o = ptr_r;

	// Transmit shifter: loaded at end of a frame, shifted on each low phase
	// Bit 7 goes to the line at load time, so only seven bits remain to shift
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_r <= 8'hff;
		end else if (load_rd) begin
			tx_r <= {rd_data_i[6:0], 1'b1};
		end else if (tx_step) begin
			tx_r <= {tx_r[6:0], 1'b1};
		end
	end

	// Data line drive; only ever changed on a falling clock edge, so the line
	// is stable while the clock is high
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sda_oe_o <= 1'b0;
		end else if (start_det || stop_det || !i2c_en_o) begin
			sda_oe_o <= 1'b0;
		end else if (byte_end) begin
			sda_oe_o <= ack_now;
		end else if (frame_end) begin
			if (state_r == i2c_port_pkg::ST_RDATA) begin
				sda_oe_o <= ~rd_data_i[7];
			end else begin
				sda_oe_o <= 1'b0;
			end
		end else if (tx_step) begin
			sda_oe_o <= ~tx_r[7];
		end else if (scl_fall && state_r == i2c_port_pkg::ST_SKIP) begin
			sda_oe_o <= 1'b0;
		end
	end

	// Open-drain: the pin is only ever pulled low, never driven high.
	// There is no clock output at all: the controller makes every pulse.
	assign sda_o = 1'b0;

	// Write queue toward the register file.
	// It lets the register file stall without stretching the bus clock.
	// A full queue makes the byte get a not-acknowledge rather than be lost.
	// Limitation: a read right after a write may overtake queued writes.
	word_fifo #(
		.WIDTH($bits(i2c_port_pkg::reg_write_t)),
		.DEPTH(FIFO_DEPTH)
	) u_wr_fifo (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(push),
		.in_ready_o(fifo_in_ready),
		.in_data_i(push_word),
		.out_valid_o(wr_valid_o),
		.out_ready_i(wr_ready_i),
		.out_data_o(pop_word)
	);

	// Queue head split onto the write port
	assign wr_addr_o = pop_word.addr;
	assign wr_data_o = pop_word.data;

endmodule // serial_port_select_i2c_target
`default_nettype wire

// File: rtl/word_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 16
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);

	// Power-of-two depth keeps the pointer wrap free
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
		$error("word_fifo: DEPTH must be a power of two, at least 2");
	end

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0] wr_ptr_r;
	logic [AW:0] rd_ptr_r;
	logic push;
	logic pop;

	// Full when pointers differ only in the wrap bit
	assign in_ready_o = (wr_ptr_r ^ rd_ptr_r) != {1'b1, {AW{1'b0}}};
	assign out_valid_o = wr_ptr_r != rd_ptr_r;
	assign out_data_o = mem_r[rd_ptr_r[AW-1:0]];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	// Storage, written only on an accepted push
	always_ff @(posedge sys_clk_i) begin
		if (push) begin
			mem_r[wr_ptr_r[AW-1:0]] <= in_data_i;
		end
	end

	// Pointers
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
		end
	end
endmodule // word_fifo
`default_nettype wire

// File: test/i2c_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_ctrl_model (
	output logic scl_o,
	output logic pull_o,
	input wire logic sda_i
);
	// Quarter of the 80 ns bus period
	localparam int Q = 20;

	// Idle bus: clock high, data released to the pull-up
	initial begin
		scl_o = 1'b1;
		pull_o = 1'b0;
	end

	// One bit: data moves mid-low and is sampled mid-high
	task automatic bit_io(input logic b, output logic r);
		#Q pull_o = !b;
		#Q scl_o = 1'b1;
		#Q r = sda_i;
		#Q scl_o = 1'b0;
	endtask

	// Long wait first so a target still holding its acknowledge has let go
	task automatic start;
		#(2 * Q) pull_o = 1'b0;
		#Q scl_o = 1'b1;
		#Q pull_o = 1'b1;
		#Q scl_o = 1'b0;
	endtask

	// Data rises while the clock is high
	task automatic stop;
		#Q pull_o = 1'b1;
		#Q scl_o = 1'b1;
		#Q pull_o = 1'b0;
		#Q;
	endtask

	// Eight bits MSB first, then the acknowledge slot
	task automatic xfer(input logic [7:0] d, input logic ack_out, output logic [7:0] q, output logic ack_in);
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(ack_out, ack_in);
	endtask

	// Partial byte, left unfinished on purpose
	task automatic bits(input int n);
		logic r;
		repeat (n) bit_io(1'b0, r);
	endtask
endmodule // i2c_ctrl_model
`default_nettype wire

// File: test/serial_port_select_i2c_target_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module serial_port_select_i2c_target_assertions #(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [1:0] port_strap_upper_i,
	input wire logic [1:0] port_strap_lower_i,
	input wire logic spi_en_o,
	input wire logic i2c_en_o,
	input wire logic [6:0] node_addr_o,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic [i2c_port_pkg::REG_ADDR_W-1:0] rd_addr_o,
	input wire logic [i2c_port_pkg::REG_DATA_W-1:0] rd_data_i,
	input wire logic wr_valid_o,
	input wire logic wr_ready_i,
	input wire logic [i2c_port_pkg::REG_ADDR_W-1:0] wr_addr_o,
	input wire logic [i2c_port_pkg::REG_DATA_W-1:0] wr_data_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	// Pad code to strap weight; 11 counts as open
	function automatic logic [2:0] lvl(input logic [1:0] c);
		return (c == 2'h2) ? 3'h2 : ((c == 2'h1) ? 3'h0 : 3'h1);
	endfunction

	// A driven low bit lasts most of a bus period
	sequence s_held;
		sda_oe_o [*6];
	endsequence

	a_spi_both_high: assert property (spi_en_o |-> port_strap_upper_i == 2'h2 && port_strap_lower_i == 2'h2)
		else $error("spi port on without both straps high");
	a_port_exclusive: assert property (!(spi_en_o && i2c_en_o))
		else $error("both ports enabled");
	a_addr_upper: assert property (i2c_en_o |-> node_addr_o[6:3] == 4'hb)
		else $error("fixed address bits wrong");
	a_addr_sum: assert property (i2c_en_o |-> node_addr_o[2:0] == 3'(lvl(port_strap_upper_i) * 3 + lvl(port_strap_lower_i)))
		else $error("strap address bits wrong");
	a_addr_frozen: assert property (i2c_en_o |=> $stable(node_addr_o) && i2c_en_o)
		else $error("node address moved");
	a_drive_scl_low: assert property ($changed(sda_oe_o) |-> !$past(scl_i, 2))
		else $error("data drive changed with clock high");
	a_ack_hold: assert property ($rose(sda_oe_o) |-> s_held)
		else $error("low drive too short");
	a_spi_quiet: assert property (!i2c_en_o |-> !sda_oe_o)
		else $error("data driven while i2c off");
	a_queue_hold: assert property (wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable({wr_addr_o, wr_data_o}))
		else $error("queue head changed while stalled");
endmodule // serial_port_select_i2c_target_assertions

bind serial_port_select_i2c_target serial_port_select_i2c_target_assertions #(.FIFO_DEPTH(FIFO_DEPTH)) chk (.*);
`default_nettype wire

// File: test/tb_serial_port_select_i2c_target.sv
`timescale 1ns/1ps
`default_nettype none
module tb_serial_port_select_i2c_target;
	localparam logic [6:0] ME = 7'h5d; // Upper open, lower high
	logic sys_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [1:0] port_strap_upper_i = 2'h0;
	logic [1:0] port_strap_lower_i = 2'h2;
	logic wr_ready_i = 1'b0;
	logic spi_en_o, i2c_en_o, scl_i, sda_i, sda_o, sda_oe_o, wr_valid_o, pull;
	logic [6:0] node_addr_o;
	logic [15:0] rd_addr_o, wr_addr_o;
	logic [7:0] rd_data_i, wr_data_o;
	int error_cnt = 0;
	int n_checks = 0;

	always #5 sys_clk_i = ~sys_clk_i;
	// Open-drain wire with pull-up; register file answers combinationally
	assign sda_i = !(pull || (sda_oe_o && !sda_o));
	assign rd_data_i = rd_addr_o[15:8] ^ rd_addr_o[7:0] ^ 8'h5a;

	i2c_ctrl_model m (.scl_o(scl_i), .pull_o(pull), .sda_i(sda_i));
	serial_port_select_i2c_target #(.FIFO_DEPTH(16)) dut (.*);

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic give_verdict;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Straps only count at reset release
	task automatic reset_to(input logic [1:0] u, input logic [1:0] l);
		@(posedge sys_clk_i);
		#1 rst_n_i = 1'b0;
		port_strap_upper_i = u;
		port_strap_lower_i = l;
		@(posedge sys_clk_i);
		#1 rst_n_i = 1'b1;
		repeat (12) @(posedge sys_clk_i);
		#1;
	endtask

	task automatic wr(input logic [7:0] d, input logic ack);
		logic [7:0] q;
		logic s;
		m.xfer(d, 1'b1, q, s);
		chk(24'(s), 24'(!ack));
	endtask

	task automatic rd(input logic [15:0] a, input logic ack);
		logic [7:0] q;
		logic s;
		m.xfer(8'hff, !ack, q, s);
		chk(24'(q), 24'(a[15:8] ^ a[7:0] ^ 8'h5a));
	endtask

	// Bounded wait for the queue head, then pop it
	task automatic pop(input logic [15:0] a, input logic [7:0] d);
		int k;
		k = 0;
		while (wr_valid_o !== 1'b1 && k < 50) begin
			@(posedge sys_clk_i);
			#1 k++;
		end
		chk(24'(wr_valid_o), 24'h00_0001);
		chk({wr_addr_o, wr_data_o}, {a, d});
		wr_ready_i = 1'b1;
		@(posedge sys_clk_i);
		#1 wr_ready_i = 1'b0;
		@(posedge sys_clk_i);
		#1;
	endtask

	// All nine strap pairs; 11 stands for open here
	task automatic t_straps;
		logic [1:0] code [3];
		code = '{2'h1, 2'h3, 2'h2};
		for (int u = 0; u < 3; u++) begin
			for (int l = 0; l < 3; l++) begin
				reset_to(code[u], code[l]);
				chk(24'(spi_en_o), 24'(u == 2 && l == 2));
				chk(24'(i2c_en_o), 24'(!(u == 2 && l == 2)));
				if (!(u == 2 && l == 2))
					chk(24'(node_addr_o), 24'({4'hb, 3'(u * 3 + l)}));
			end
		end
		m.start;
		wr(8'hb0, 1'b0);
		m.stop;
	endtask

	// Sixteen writes fill the stalled queue, the next is refused
	task automatic t_full;
		m.start;
		wr({ME, 1'b0}, 1'b1);
		wr(8'h20, 1'b1);
		wr(8'h00, 1'b1);
		for (int i = 0; i < 16; i++) wr(8'(i * 17 + 1), 1'b1);
		wr(8'h77, 1'b0);
		m.stop;
		for (int i = 0; i < 16; i++) pop(16'(16'h2000 + i), 8'(i * 17 + 1));
		repeat (4) @(posedge sys_clk_i);
		#1;
		chk(24'(wr_valid_o), 24'h00_0000);
	endtask

	// Set pointer, repeated start, read across a carry, refuse the last
	task automatic t_read;
		m.start;
		wr({ME, 1'b0}, 1'b1);
		wr(8'h01, 1'b1);
		wr(8'hfe, 1'b1);
		m.start;
		wr({ME, 1'b1}, 1'b1);
		rd(16'h01fe, 1'b1);
		rd(16'h01ff, 1'b1);
		rd(16'h0200, 1'b0);
		chk(24'(sda_oe_o), 24'h00_0000);
		chk(24'(sda_o), 24'h00_0000);
		chk(24'(rd_addr_o), 24'h00_0201);
		m.stop;
	endtask

	// Other node addresses get no answer at all
	task automatic t_miss;
		logic [7:0] q;
		logic s;
		m.start;
		wr({7'h58, 1'b0}, 1'b0);
		wr(8'h00, 1'b0);
		m.start;
		wr({7'h5c, 1'b1}, 1'b0);
		m.xfer(8'hff, 1'b0, q, s);
		chk(24'(q), 24'h00_00ff);
		m.stop;
		chk(24'(wr_valid_o), 24'h00_0000);
	endtask

	// Half a byte cut by a repeated start, then a whole one
	task automatic t_abort;
		m.start;
		wr({ME, 1'b0}, 1'b1);
		wr(8'h30, 1'b1);
		wr(8'h00, 1'b1);
		m.bits(4);
		m.start;
		wr({ME, 1'b0}, 1'b1);
		wr(8'h30, 1'b1);
		wr(8'h00, 1'b1);
		wr(8'h99, 1'b1);
		m.bits(5);
		m.stop;
		pop(16'h3000, 8'h99);
		repeat (4) @(posedge sys_clk_i);
		#1;
		chk(24'(wr_valid_o), 24'h00_0000);
	endtask

	// Main sequence
	initial begin
		repeat (3) @(posedge sys_clk_i);
		#1 rst_n_i = 1'b1;
		t_straps;
		reset_to(2'h0, 2'h2);
		t_full;
		t_read;
		t_miss;
		t_abort;
		give_verdict;
	end

	// Hang guard, several times the expected run
	initial begin
		#300000;
		error_cnt++;
		$display("MISMATCH %0t watchdog expired", $time);
		give_verdict;
	end
endmodule // tb_serial_port_select_i2c_target
`default_nettype wire
